// ===== common/mps_pkg.sv
package mps_pkg;
  // register byte offsets
  localparam logic [7:0] REG_STRAP_LO = 8'h00;
  localparam logic [7:0] REG_STRAP_HI = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_ROM_ADDR = 8'h0c;
  localparam logic [7:0] REG_ROM_STAT = 8'h10;
  // control fields
  localparam int CTRL_MEM_EN = 0;
  localparam int CTRL_CLKOUT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // rom status fields
  localparam int STAT_BUSY = 8;
  localparam int STAT_FLOAT = 9;
  localparam int STAT_ICT = 10;
  localparam int STAT_VALID = 11;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_NS = 5;
  localparam int ROM_SETUP_NS = 10;
  localparam int ROM_ACCESS_NS = 150;
  localparam int ROM_SETUP_CYC = (ROM_SETUP_NS + CLK_NS - 1) / CLK_NS;
  // two extra cycles cover the input synchroniser, one the output register
  localparam int ROM_ACCESS_CYC = (ROM_ACCESS_NS + CLK_NS - 1) / CLK_NS + 3;

  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } mps_pins16_t;

  typedef enum logic [1:0] {ROM_IDLE, ROM_SETUP, ROM_ACCESS} mps_rom_state_t;
endpackage

// ===== hw/mps_pin_share.sv
// Behaviour
// - drive ten shared dram bank address pins
// - address pins are strap bits 9..0
// - data pins 7..2 are strap bits 15..10
// - latch data pins 7..2 into high strap register
// - low data pins carry dram data 15..0
// - data pin0 floats outputs, pin1 enables ict
// - rom data read on pins 15..8 before enable
// - active-low rom enable, or memclk in test
// - mid data pins drive rom address 15..0
// - top data pins 12..11 drive rom address 17..16
// - host rom accesses pass through this block
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module mps_pin_share
  import mps_pkg::*;
#(
  parameter int AA_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [AA_W-1:0] aa_in,
  output logic [AA_W-1:0] aa_out,
  output logic [AA_W-1:0] aa_oe,
  input wire logic [15:0] mem_data_low_in,
  output mps_pins16_t mem_data_low,
  input wire logic [15:0] mem_data_mid_in,
  output mps_pins16_t mem_data_mid,
  input wire logic [1:0] mem_data_top_in,
  output logic [1:0] mem_data_top_out,
  output logic [1:0] mem_data_top_oe,
  output logic rom_output_enable_n,
  input wire logic [AA_W-1:0] dram_addr,
  input wire logic [31:0] dram_wdata,
  input wire logic dram_wdata_oe,
  output logic [31:0] dram_rdata,
  output logic [15:0] strap_cfg,
  output logic straps_valid,
  output logic mem_if_enabled
);

  logic [AA_W-1:0] aa_s1, aa_s2;
  logic [15:0] low_s1, low_s2, mid_s1, mid_s2;
  logic [1:0] top_s1, top_s2;
  logic test_float_enable, test_incircuit_enable;
  logic [7:0] strap_status_reg_lo, strap_status_reg_hi;
  logic [1:0] ctrl;
  logic [17:0] rom_address;
  logic [7:0] rom_data_in;
  logic [7:0] rom_cnt;
  logic memclk_test_out;
  logic rom_capture;
  mps_rom_state_t rom_state;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go, rom_start;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      REG_STRAP_LO: read_word = {24'h0, strap_status_reg_lo};
      REG_STRAP_HI: read_word = {24'h0, strap_status_reg_hi};
      REG_CTRL: read_word = {30'h0, ctrl};
      REG_ROM_ADDR: read_word = {14'h0, rom_address};
      REG_ROM_STAT: read_word = {20'h0, straps_valid, test_incircuit_enable,
                                 test_float_enable, rom_state != ROM_IDLE, rom_data_in};
      default: read_word = 32'h0;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == REG_STRAP_LO) || (a == REG_STRAP_HI) || (a == REG_CTRL) ||
                (a == REG_ROM_ADDR) || (a == REG_ROM_STAT);
  endfunction

  // no reset: the synchronisers must follow the straps while reset is held
  always_ff @(posedge aclk) begin
    aa_s1 <= aa_in;
    aa_s2 <= aa_s1;
    low_s1 <= mem_data_low_in;
    low_s2 <= low_s1;
    mid_s1 <= mem_data_mid_in;
    mid_s2 <= mid_s1;
    top_s1 <= mem_data_top_in;
    top_s2 <= top_s1;
  end

  // straps and test pins captured on the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_valid <= 1'b0;
      strap_cfg <= 16'h0;
      strap_status_reg_lo <= 8'h0;
      strap_status_reg_hi <= 8'h0;
      test_float_enable <= 1'b0;
      test_incircuit_enable <= 1'b0;
    end else if (!straps_valid) begin
      straps_valid <= 1'b1;
      strap_cfg <= {low_s2[7:2], aa_s2};
      strap_status_reg_lo <= aa_s2[7:0];
      strap_status_reg_hi <= {low_s2[7:2], aa_s2[9:8]};
      test_float_enable <= low_s2[0];
      test_incircuit_enable <= low_s2[1];
    end
  end

  // axi4-lite write: address and data taken in either order
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign rom_start = wr_go && (aw_addr == REG_ROM_ADDR) && (w_strb[2:0] == 3'h7) &&
                     !ctrl[CTRL_MEM_EN] && rom_state == ROM_IDLE && straps_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      rom_address <= 18'h0;
    end else if (wr_go && w_strb[0] && aw_addr == REG_CTRL) begin
      ctrl <= w_data[1:0];
    end else if (rom_start) begin
      rom_address <= w_data[17:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr);
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // rom read sequencer, only before the memory interface is enabled
  assign rom_capture = (rom_state == ROM_ACCESS) && (rom_cnt == 8'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_state <= ROM_IDLE;
      rom_cnt <= 8'h0;
      rom_data_in <= 8'h0;
    end else begin
      case (rom_state)
        ROM_IDLE: begin
          if (rom_start) begin
            rom_state <= ROM_SETUP;
            rom_cnt <= 8'(ROM_SETUP_CYC);
          end
        end
        ROM_SETUP: begin
          if (rom_cnt == 8'h0) begin
            rom_state <= ROM_ACCESS;
            rom_cnt <= 8'(ROM_ACCESS_CYC);
          end else begin
            rom_cnt <= rom_cnt - 8'h1;
          end
        end
        ROM_ACCESS: begin
          if (rom_capture) begin
            rom_data_in <= low_s2[15:8];
            rom_state <= ROM_IDLE;
          end else begin
            rom_cnt <= rom_cnt - 8'h1;
          end
        end
        default: rom_state <= ROM_IDLE;
      endcase
    end
  end

  // pin drivers; nothing is driven until the straps are safely held
  always_ff @(posedge aclk) begin
    if (!aresetn || !straps_valid || test_float_enable) begin
      aa_out <= '0;
      aa_oe <= '0;
      mem_data_low <= '0;
      mem_data_mid <= '0;
      mem_data_top_out <= 2'h0;
      mem_data_top_oe <= 2'h0;
    end else if (rom_state != ROM_IDLE) begin
      aa_oe <= '0;
      mem_data_low.oe <= 16'h0;
      mem_data_mid.o <= rom_address[15:0];
      mem_data_mid.oe <= 16'hffff;
      mem_data_top_out <= rom_address[17:16];
      mem_data_top_oe <= 2'h3;
    end else if (ctrl[CTRL_MEM_EN]) begin
      aa_out <= dram_addr;
      aa_oe <= '1;
      mem_data_low.o <= dram_wdata[15:0];
      mem_data_low.oe <= {16{dram_wdata_oe}};
      mem_data_mid.o <= dram_wdata[31:16];
      mem_data_mid.oe <= {16{dram_wdata_oe}};
      mem_data_top_oe <= 2'h0;
    end else begin
      aa_oe <= '0;
      mem_data_low.oe <= 16'h0;
      mem_data_mid.oe <= 16'h0;
      mem_data_top_oe <= 2'h0;
    end
  end

  // test clock out is half the core clock: a flop output cannot carry the clock itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memclk_test_out <= 1'b0;
      rom_output_enable_n <= 1'b1;
    end else begin
      memclk_test_out <= !memclk_test_out;
      if (ctrl[CTRL_CLKOUT] && test_incircuit_enable) begin
        rom_output_enable_n <= memclk_test_out;
      end else begin
        rom_output_enable_n <= !(rom_state == ROM_ACCESS && !test_float_enable);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dram_rdata <= 32'h0;
      mem_if_enabled <= 1'b0;
    end else begin
      dram_rdata <= {mid_s2, low_s2};
      mem_if_enabled <= ctrl[CTRL_MEM_EN];
    end
  end

  a_reset_undriven: assert property (@(posedge aclk)
    !aresetn |=> (aa_oe == '0 && mem_data_low.oe == 16'h0 && mem_data_mid.oe == 16'h0))
    else $error("pins driven during reset");
  a_strap_low_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(straps_valid) |-> strap_cfg[9:0] == $past(aa_s2))
    else $error("address straps not captured");
  a_strap_high_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(straps_valid) |-> strap_cfg[15:10] == $past(low_s2[7:2]))
    else $error("data straps not captured");
  a_strap_status_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    straps_valid |-> strap_status_reg_hi[7:2] == strap_cfg[15:10])
    else $error("high strap register mismatch");
  a_dram_addr_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (straps_valid && !test_float_enable && ctrl[CTRL_MEM_EN] && rom_state == ROM_IDLE)
    |=> (aa_out == $past(dram_addr) && aa_oe == '1))
    else $error("dram address not driven");
  a_rom_addr_mid: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_state == ROM_SETUP && !test_float_enable)
    |=> (mem_data_mid.o == rom_address[15:0] && mem_data_mid.oe == 16'hffff))
    else $error("rom address low not driven");
  a_rom_addr_top: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_state == ROM_SETUP && !test_float_enable)
    |=> (mem_data_top_out == rom_address[17:16] && mem_data_top_oe == 2'h3))
    else $error("rom address high not driven");
  a_rom_oe_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_state == ROM_IDLE ##1 (rom_state == ROM_SETUP && !ctrl[CTRL_CLKOUT]))
    |-> rom_output_enable_n [*2])
    else $error("rom enable before address setup");
  a_rom_sample_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_capture && !ctrl[CTRL_CLKOUT]) |-> !rom_output_enable_n && $past(!rom_output_enable_n))
    else $error("rom sampled without enable");
  a_float_outputs: assert property (@(posedge aclk) disable iff (!aresetn)
    test_float_enable |=> (aa_oe == '0 && mem_data_mid.oe == 16'h0 && mem_data_top_oe == 2'h0))
    else $error("outputs driven in float test");
  a_rom_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[CTRL_MEM_EN] && rom_state == ROM_IDLE) |=> rom_state == ROM_IDLE)
    else $error("rom read after memory enable");
  // low pins must stay released while the rom drives its data onto them
  a_rom_low_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    rom_state != ROM_IDLE |=> mem_data_low.oe == 16'h0)
    else $error("low data pins driven during rom read");
  a_rom_oe_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (rom_state == ROM_IDLE && !ctrl[CTRL_CLKOUT]) |=> rom_output_enable_n)
    else $error("rom enable low while idle");
  a_low_dram_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (straps_valid && !test_float_enable && ctrl[CTRL_MEM_EN] && rom_state == ROM_IDLE)
    |=> (mem_data_low.o == $past(dram_wdata[15:0]) &&
         mem_data_low.oe == {16{$past(dram_wdata_oe)}}))
    else $error("dram data not driven on low pins");
  a_top_dram_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[CTRL_MEM_EN] && rom_state == ROM_IDLE) |=> mem_data_top_oe == 2'h0)
    else $error("rom address high driven in dram mode");
  a_strap_status_lo: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(straps_valid) |-> strap_status_reg_lo == $past(aa_s2[7:0]))
    else $error("low strap register not captured");

endmodule // mps_pin_share

// ===== testbench/mps_far_model.sv
`timescale 1ns/1ps
module mps_far_model
  import mps_pkg::*;
#(
  parameter logic [9:0] STRAP_AA = 10'h2c9,
  parameter logic [5:0] STRAP_HI = 6'h2b,
  parameter int RDLY = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] test_pins,
  input wire logic [9:0] aa_out,
  input wire logic [9:0] aa_oe,
  output logic [9:0] aa_in,
  input wire mps_pins16_t mem_data_low,
  output logic [15:0] mem_data_low_in,
  input wire mps_pins16_t mem_data_mid,
  output logic [15:0] mem_data_mid_in,
  input wire logic [1:0] mem_data_top_out,
  input wire logic [1:0] mem_data_top_oe,
  output logic [1:0] mem_data_top_in,
  input wire logic rom_output_enable_n
);
  logic [31:0] mem = 32'h0;
  int cnt = 0;
  logic [17:0] ra;
  logic [15:0] lo;
  assign ra = {mem_data_top_out, mem_data_mid.o};
  // one stored word stands in for the banks
  always @(posedge aclk) begin
    if (&mem_data_low.oe && &mem_data_mid.oe) mem <= {mem_data_mid.o, mem_data_low.o};
    cnt <= rom_output_enable_n ? 0 : cnt + 1;
  end
  // resistors: oscillator strap low, host bus strap high
  assign aa_in = (aa_oe & aa_out) | (~aa_oe & STRAP_AA);
  // slow rom: junk that toggles until its access time runs out
  always_comb begin
    lo = mem[15:0];
    if (!aresetn) lo[7:0] = {STRAP_HI, test_pins};
    if (!rom_output_enable_n) lo[15:8] = (cnt >= RDLY) ?
        ra[7:0] ^ ra[15:8] ^ {6'h0, ra[17:16]} : {4{cnt[0], ~cnt[0]}};
  end
  assign mem_data_low_in = (mem_data_low.oe & mem_data_low.o) | (~mem_data_low.oe & lo);
  assign mem_data_mid_in = (mem_data_mid.oe & mem_data_mid.o) | (~mem_data_mid.oe & mem[31:16]);
  assign mem_data_top_in = ~mem_data_top_out;
endmodule // mps_far_model

// ===== testbench/memory_pin_strap_rom_share_test.sv
`timescale 1ns/1ps
module memory_pin_strap_rom_share_test;
  import mps_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, dram_wdata_oe = 0, v;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic straps_valid, mem_if_enabled, rom_output_enable_n;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, dram_wdata = 0, s_axi_rdata, dram_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_data_top_in, mem_data_top_out, mem_data_top_oe;
  logic [1:0] test_pins = 0, rsp;
  logic [9:0] aa_in, aa_out, aa_oe, dram_addr = 0;
  logic [15:0] mem_data_low_in, mem_data_mid_in, strap_cfg;
  mps_pins16_t mem_data_low, mem_data_mid;
  int fail_count = 0, checked = 0;
  always #2.5 aclk = ~aclk;
  mps_pin_share u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .aa_in(aa_in), .aa_out(aa_out), .aa_oe(aa_oe),
    .mem_data_low_in(mem_data_low_in), .mem_data_low(mem_data_low),
    .mem_data_mid_in(mem_data_mid_in), .mem_data_mid(mem_data_mid),
    .mem_data_top_in(mem_data_top_in), .mem_data_top_out(mem_data_top_out),
    .mem_data_top_oe(mem_data_top_oe), .rom_output_enable_n(rom_output_enable_n),
    .dram_addr(dram_addr), .dram_wdata(dram_wdata), .dram_wdata_oe(dram_wdata_oe),
    .dram_rdata(dram_rdata), .strap_cfg(strap_cfg), .straps_valid(straps_valid),
    .mem_if_enabled(mem_if_enabled)
  );
  mps_far_model u_far (
    .aclk(aclk), .aresetn(aresetn), .test_pins(test_pins),
    .aa_out(aa_out), .aa_oe(aa_oe), .aa_in(aa_in),
    .mem_data_low(mem_data_low), .mem_data_low_in(mem_data_low_in),
    .mem_data_mid(mem_data_mid), .mem_data_mid_in(mem_data_mid_in),
    .mem_data_top_out(mem_data_top_out), .mem_data_top_oe(mem_data_top_oe),
    .mem_data_top_in(mem_data_top_in), .rom_output_enable_n(rom_output_enable_n)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // waits have no limit of their own: only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    // one edge with bready low, so a following call never rewrites it in this step
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic rst();
    aresetn <= 0;
    cyc(2);
    chk(aa_oe | mem_data_low.oe | mem_data_mid.oe | mem_data_top_oe, 0);
    chk(rom_output_enable_n, 1);
    cyc(2);
    aresetn <= 1;
    cyc(2);
    chk(straps_valid, 1);
  endtask
  task automatic t_straps();
    chk(strap_cfg, {6'h2b, 10'h2c9});
    rdr(REG_STRAP_LO);
    chk(rd, 8'hc9);
    rdr(REG_STRAP_HI);
    chk(rd, {6'h2b, 2'b10});
    rdr(REG_ROM_STAT);
    chk(rd[STAT_ICT:STAT_FLOAT], 0);
    chk(rd[STAT_VALID], 1);
    $display("straps done");
  endtask
  task automatic t_rom(input logic [17:0] a);
    wr(REG_ROM_ADDR, {14'h0, a});
    chk(rsp, RESP_OKAY);
    cyc(3);
    chk(rom_output_enable_n, 0);
    chk({mem_data_mid.oe, mem_data_mid.o}, {16'hffff, a[15:0]});
    chk({mem_data_top_oe, mem_data_top_out}, {2'b11, a[17:16]});
    cyc(40);
    chk(mem_data_mid.oe, 0);
    rdr(REG_ROM_STAT);
    chk(rd[8:0], {1'b0, a[7:0] ^ a[15:8] ^ {6'h0, a[17:16]}});
    $display("rom read done");
  endtask
  task automatic t_bus();
    wr(8'h14, 32'h1);
    chk(rsp, RESP_SLVERR);
    rdr(8'h14);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0});
    $display("unmapped done");
  endtask
  task automatic t_dram();
    // test clock select must be ignored without the ict strap
    wr(REG_CTRL, 32'h3);
    dram_addr <= 10'h155;
    dram_wdata <= 32'hc3a55a3c;
    dram_wdata_oe <= 1;
    cyc(3);
    chk({mem_if_enabled, rom_output_enable_n}, 2'b11);
    chk({aa_oe, aa_out}, {10'h3ff, 10'h155});
    chk({mem_data_mid.o, mem_data_low.o}, 32'hc3a55a3c);
    chk(mem_data_low.oe, 16'hffff);
    dram_wdata_oe <= 0;
    cyc(5);
    chk(dram_rdata, 32'hc3a55a3c);
    wr(REG_ROM_ADDR, 32'h155);
    rdr(REG_ROM_STAT);
    chk({rd[STAT_BUSY], rom_output_enable_n}, 2'b01);
    $display("dram mode done");
  endtask
  task automatic t_float();
    test_pins <= 2'b11;
    rst();
    rdr(REG_ROM_STAT);
    chk(rd[STAT_ICT:STAT_FLOAT], 2'b11);
    wr(REG_CTRL, 32'h3);
    dram_wdata_oe <= 1;
    cyc(3);
    chk(aa_oe | mem_data_low.oe | mem_data_mid.oe, 0);
    v = rom_output_enable_n;
    cyc(1);
    chk(rom_output_enable_n ^ v, 1);
    $display("test mode done");
  endtask
  initial begin
    rst();
    t_straps();
    t_rom(18'h2a5c3);
    t_rom(18'h1ffff);
    t_bus();
    t_dram();
    t_float();
    end_sim();
  end
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
endmodule // memory_pin_strap_rom_share_test
